// file: sim/ext_pin_timer_irq_bits_tb.sv
// self-checking bench for the primary interrupt control block
`timescale 1ns/1ps
module ext_pin_timer_irq_bits_tb;
	import irq_ctrl_pkg::*;
	logic clk_sys_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0;
	logic [31:0] prdata_o, r;
	logic pready_o, pslverr_o, core_irq_o, irq_o, e, t;
	logic [3:0] p;
	int err_count = 0;
	int total_checks = 0;
	always #2.5 clk_sys_i = ~clk_sys_i;
	pin_model u_pin_model (.clk_i(clk_sys_i), .edge_o(e), .port_o(p),
		.tmr_o(t));
	ext_pin_timer_irq_bits u_ext_pin_timer_irq_bits (.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.edge_interrupt_pin_i(e), .upper_port_pins_i(p),
		.timer_overflow_i(t), .core_irq_o(core_irq_o), .irq_o(irq_o));
	task automatic print_verdict();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_sys_i);
		penable_i <= 1'b1;
		do
		begin
			@(posedge clk_sys_i);
			n++;
		end
		while (pready_o !== 1'b1 && n < 20);
		r = prdata_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		if (pready_o !== 1'b1)
		begin
			err_count++;
			print_verdict();
		end
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(r, exp);
	endtask
	initial
	begin
		repeat (8) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		rdc(ADDR_CTRL, {24'h0, CTRL_RESET});
		rdc(ADDR_CFG, {30'h0, CFG_RESET});
		rdc(12'h020, UNMAPPED_DATA);
		u_pin_model.tick();
		rdc(ADDR_CTRL, 32'h4);
		rdc(ADDR_CTRL, 32'h4);
		bus(1'b1, ADDR_CTRL, 32'h0);
		rdc(ADDR_CTRL, 32'h0);
		u_pin_model.pins(1'b1, 4'h0);
		// sync plus edge detect plus flag load
		repeat (6) @(posedge clk_sys_i);
		rdc(ADDR_CTRL, 32'h2);
		bus(1'b1, ADDR_CFG, 32'h3);
		#1 chk({30'h0, pready_o, pslverr_o}, 32'h2);
		chk({31'h0, core_irq_o}, 32'h0);
		bus(1'b1, ADDR_CTRL, 32'h12);
		#1 chk({31'h0, core_irq_o}, 32'h1);
		bus(1'b1, ADDR_CTRL, 32'h10);
		#1 chk({31'h0, core_irq_o}, 32'h0);
		bus(1'b1, ADDR_CFG, 32'h2);
		u_pin_model.pins(1'b0, 4'h0);
		repeat (6) @(posedge clk_sys_i);
		rdc(ADDR_CTRL, 32'h12);
		bus(1'b1, ADDR_CTRL, 32'h0);
		u_pin_model.pins(1'b1, 4'h5);
		repeat (6) @(posedge clk_sys_i);
		rdc(ADDR_CTRL, 32'h1);
		bus(1'b1, ADDR_CTRL, 32'h8);
		rdc(ADDR_CTRL, 32'h9);
		#1 chk({31'h0, core_irq_o}, 32'h1);
		rdc(ADDR_PORT, 32'h5);
		bus(1'b1, ADDR_CTRL, 32'h8);
		rdc(ADDR_CTRL, 32'h8);
		u_pin_model.tick();
		bus(1'b1, ADDR_MASK, 32'h4);
		#1 chk({31'h0, irq_o}, 32'h1);
		bus(1'b1, ADDR_MASK, 32'h0);
		#1 chk({31'h0, irq_o}, 32'h0);
		rdc(ADDR_STAT, 32'h7);
		bus(1'b1, ADDR_STAT, 32'h4);
		rdc(ADDR_STAT, 32'h3);
		print_verdict();
	end
endmodule

// file: sim/pin_model.sv
// far-side model: edge pin, upper port pins and timer overflow pulse
`timescale 1ns/1ps
module pin_model
(
	input wire logic clk_i,
	output logic edge_o,
	output logic [3:0] port_o,
	output logic tmr_o
);
	initial
	begin
		edge_o = 1'b0;
		port_o = 4'h0;
		tmr_o = 1'b0;
	end
	task automatic pins(input logic e, input logic [3:0] p);
		@(posedge clk_i);
		edge_o <= e;
		port_o <= p;
	endtask
	// overflow is a single-cycle pulse in the system clock domain
	task automatic tick();
		@(posedge clk_i);
		tmr_o <= 1'b1;
		@(posedge clk_i);
		tmr_o <= 1'b0;
	endtask
endmodule

// file: verilog/ext_pin_timer_irq_bits.sv
// primary interrupt control: edge pin, port change and timer overflow flags
`timescale 1ns/1ps
// Summary of operation
// - edge pin request reaches the core request only with enable bit 4 set
// - port change request reaches the core request only with enable bit 3 set
// - timer overflow sets flag bit 2; only software clears it
// - edge pin event sets flag bit 1 until software clears it
// - any upper port pin change sets flag bit 0 until cleared
// - a standing mismatch keeps re-setting the port change flag
// - reading the port data register latches pins, ending the mismatch
// - flags set on their condition regardless of any enable
// - edge pin triggers rising when polarity select is 1, else falling
module ext_pin_timer_irq_bits
	import irq_ctrl_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic edge_interrupt_pin_i,
	input wire logic [3:0] upper_port_pins_i,
	input wire logic timer_overflow_i,
	output logic core_irq_o,
	output logic irq_o
);
	logic [7:0] ctrl_q;
	logic [1:0] cfg_q;
	logic [NUM_EV-1:0] stat_q;
	logic [NUM_EV-1:0] mask_q;
	logic edge_s1_q, edge_s2_q, edge_s3_q;
	logic [3:0] port_s1_q, port_s2_q, port_latch_q;
	logic [31:0] rdata_q;
	logic wr_en, rd_en, edge_ev, mismatch, port_rd;
	logic [NUM_EV-1:0] ev;
	logic [7:0] ctrl_clr;

	assign wr_en = psel_i & penable_i & pwrite_i;
	assign rd_en = psel_i & penable_i & ~pwrite_i;
	assign port_rd = rd_en & (paddr_i == ADDR_PORT);
	assign pready_o = 1'b1;
	assign pslverr_o = 1'b0;
	assign prdata_o = rdata_q;

	// pins are asynchronous: two flops before anything looks at them
	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			edge_s1_q <= 1'b0;
			edge_s2_q <= 1'b0;
			edge_s3_q <= 1'b0;
			port_s1_q <= 4'h0;
			port_s2_q <= 4'h0;
		end
		else
		begin
			edge_s1_q <= edge_interrupt_pin_i;
			edge_s2_q <= edge_s1_q;
			edge_s3_q <= edge_s2_q;
			port_s1_q <= upper_port_pins_i;
			port_s2_q <= port_s1_q;
		end
	end

	assign edge_ev = cfg_q[POL_BIT] ? (edge_s2_q & ~edge_s3_q)
		: (~edge_s2_q & edge_s3_q);

	// latch taken on a port read; mismatch persists until then
	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			port_latch_q <= 4'h0;
		else if (port_rd)
			port_latch_q <= port_s2_q;
	end

	assign mismatch = (port_s2_q != port_latch_q) & ~port_rd;

	always_comb
	begin
		ev = '0;
		ev[TMR_FLAG_BIT] = timer_overflow_i;
		ev[EDGE_FLAG_BIT] = edge_ev;
		ev[PORT_FLAG_BIT] = mismatch;
	end

	// software clears flags by writing zero; a same-cycle event wins
	always_comb
	begin
		ctrl_clr = '0;
		if (wr_en && paddr_i == ADDR_CTRL)
			ctrl_clr = ~pwdata_i[7:0];
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			ctrl_q <= CTRL_RESET;
		else
		begin
			if (wr_en && paddr_i == ADDR_CTRL)
				ctrl_q[7:NUM_EV] <= pwdata_i[7:NUM_EV];
			ctrl_q[NUM_EV-1:0] <= (ctrl_q[NUM_EV-1:0]
				& ~ctrl_clr[NUM_EV-1:0]) | ev;
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			cfg_q <= CFG_RESET;
		else if (wr_en && paddr_i == ADDR_CFG)
			cfg_q <= pwdata_i[1:0];
	end

	// sticky status mirrors the same events, write one to clear
	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			stat_q <= EV_RESET;
		else if (wr_en && paddr_i == ADDR_STAT)
			stat_q <= (stat_q & ~pwdata_i[NUM_EV-1:0]) | ev;
		else
			stat_q <= stat_q | ev;
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			mask_q <= EV_RESET;
		else if (wr_en && paddr_i == ADDR_MASK)
			mask_q <= pwdata_i[NUM_EV-1:0];
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			rdata_q <= UNMAPPED_DATA;
		else if (psel_i && !penable_i && !pwrite_i)
		begin
			case (paddr_i)
				ADDR_CTRL: rdata_q <= {24'h0, ctrl_q};
				ADDR_PORT: rdata_q <= {28'h0, port_s2_q};
				ADDR_CFG: rdata_q <= {30'h0, cfg_q};
				ADDR_STAT: rdata_q <= {29'h0, stat_q};
				ADDR_MASK: rdata_q <= {29'h0, mask_q};
				default: rdata_q <= UNMAPPED_DATA;
			endcase
		end
	end

	// timer overflow enable lives elsewhere; the core request covers two
	assign core_irq_o = cfg_q[GLB_EN_BIT] & (
		(ctrl_q[EDGE_EN_BIT] & ctrl_q[EDGE_FLAG_BIT]) |
		(ctrl_q[PORT_EN_BIT] & ctrl_q[PORT_FLAG_BIT]));
	assign irq_o = |(stat_q & mask_q);

	a_edge_gate: assert property (@(posedge clk_sys_i)
		disable iff (!arst_n_i)
		!ctrl_q[EDGE_EN_BIT] && !ctrl_q[PORT_EN_BIT] |-> !core_irq_o)
		else $error("request raised with both enables low");
	a_port_gate: assert property (@(posedge clk_sys_i)
		disable iff (!arst_n_i)
		cfg_q[GLB_EN_BIT] && ctrl_q[PORT_EN_BIT] && ctrl_q[PORT_FLAG_BIT]
		|-> core_irq_o)
		else $error("port change request missing");
	a_tmr_set: assert property (@(posedge clk_sys_i)
		disable iff (!arst_n_i)
		timer_overflow_i |=> ctrl_q[TMR_FLAG_BIT])
		else $error("timer flag not set on overflow");
	a_tmr_hold: assert property (@(posedge clk_sys_i)
		disable iff (!arst_n_i)
		ctrl_q[TMR_FLAG_BIT] && !(wr_en && paddr_i == ADDR_CTRL)
		|=> ctrl_q[TMR_FLAG_BIT])
		else $error("timer flag dropped without a write");
	sequence s_rise;
		cfg_q[POL_BIT] && !edge_s3_q ##1 edge_s3_q;
	endsequence
	a_edge_set: assert property (@(posedge clk_sys_i)
		disable iff (!arst_n_i)
		s_rise |=> ctrl_q[EDGE_FLAG_BIT])
		else $error("edge flag not set after rising edge");
	a_port_set: assert property (@(posedge clk_sys_i)
		disable iff (!arst_n_i)
		mismatch |=> ctrl_q[PORT_FLAG_BIT] && stat_q[PORT_FLAG_BIT])
		else $error("port flag not set on mismatch");
	a_port_latch: assert property (@(posedge clk_sys_i)
		disable iff (!arst_n_i)
		port_rd |=> port_latch_q == $past(port_s2_q))
		else $error("port read did not latch pins");
	a_poll_flag: assert property (@(posedge clk_sys_i)
		disable iff (!arst_n_i)
		edge_ev && !ctrl_q[EDGE_EN_BIT] |=> ctrl_q[EDGE_FLAG_BIT])
		else $error("flag not set while disabled");
	a_core_req: assert property (@(posedge clk_sys_i)
		disable iff (!arst_n_i)
		!cfg_q[GLB_EN_BIT] |-> !core_irq_o)
		else $error("request raised with global enable low");

	// gating of the core request by the two in-scope enables
	a_edge_pass: assert property (@(posedge clk_sys_i)
		disable iff (!arst_n_i)
		cfg_q[GLB_EN_BIT] && ctrl_q[EDGE_EN_BIT]
		&& ctrl_q[EDGE_FLAG_BIT] |-> core_irq_o)
		else $error("edge pin request missing");

	a_edge_mask: assert property (@(posedge clk_sys_i)
		disable iff (!arst_n_i)
		!ctrl_q[EDGE_EN_BIT] && !ctrl_q[PORT_FLAG_BIT] |-> !core_irq_o)
		else $error("masked edge pin request reached the core");

	a_port_mask: assert property (@(posedge clk_sys_i)
		disable iff (!arst_n_i)
		!ctrl_q[PORT_EN_BIT] && !ctrl_q[EDGE_FLAG_BIT] |-> !core_irq_o)
		else $error("masked port change request reached the core");

	a_en_hold: assert property (@(posedge clk_sys_i)
		disable iff (!arst_n_i)
		!(wr_en && paddr_i == ADDR_CTRL)
		|=> $stable(ctrl_q[EDGE_EN_BIT]))
		else $error("edge enable changed without a write");

	a_en3_hold: assert property (@(posedge clk_sys_i)
		disable iff (!arst_n_i)
		!(wr_en && paddr_i == ADDR_CTRL)
		|=> $stable(ctrl_q[PORT_EN_BIT]))
		else $error("port enable changed without a write");

	a_tmr_stat: assert property (@(posedge clk_sys_i)
		disable iff (!arst_n_i)
		timer_overflow_i |=> stat_q[TMR_FLAG_BIT])
		else $error("timer status not set on overflow");

	a_tmr_clear: assert property (@(posedge clk_sys_i)
		disable iff (!arst_n_i)
		wr_en && paddr_i == ADDR_CTRL && !pwdata_i[TMR_FLAG_BIT]
		&& !timer_overflow_i |=> !ctrl_q[TMR_FLAG_BIT])
		else $error("timer flag not cleared by software");

	a_edge_hold: assert property (@(posedge clk_sys_i)
		disable iff (!arst_n_i)
		ctrl_q[EDGE_FLAG_BIT] && !(wr_en && paddr_i == ADDR_CTRL)
		|=> ctrl_q[EDGE_FLAG_BIT])
		else $error("edge flag dropped without a write");

	a_edge_clear: assert property (@(posedge clk_sys_i)
		disable iff (!arst_n_i)
		wr_en && paddr_i == ADDR_CTRL && !pwdata_i[EDGE_FLAG_BIT]
		&& !edge_ev |=> !ctrl_q[EDGE_FLAG_BIT])
		else $error("edge flag not cleared by software");

	a_edge_quiet: assert property (@(posedge clk_sys_i)
		disable iff (!arst_n_i)
		!ctrl_q[EDGE_FLAG_BIT] && !edge_ev |=> !ctrl_q[EDGE_FLAG_BIT])
		else $error("edge flag set with no event");

	a_port_hold: assert property (@(posedge clk_sys_i)
		disable iff (!arst_n_i)
		ctrl_q[PORT_FLAG_BIT] && !(wr_en && paddr_i == ADDR_CTRL)
		|=> ctrl_q[PORT_FLAG_BIT])
		else $error("port flag dropped without a write");

	a_port_quiet: assert property (@(posedge clk_sys_i)
		disable iff (!arst_n_i)
		!ctrl_q[PORT_FLAG_BIT] && !mismatch |=> !ctrl_q[PORT_FLAG_BIT])
		else $error("port flag set with no change");

	// a clear that meets a standing mismatch must lose
	a_mis_reset: assert property (@(posedge clk_sys_i)
		disable iff (!arst_n_i)
		mismatch && wr_en && paddr_i == ADDR_CTRL
		|=> ctrl_q[PORT_FLAG_BIT])
		else $error("port flag cleared during a mismatch");

	a_mis_end: assert property (@(posedge clk_sys_i)
		disable iff (!arst_n_i)
		port_rd ##1 $stable(port_s2_q) |-> !mismatch)
		else $error("mismatch kept after a port read");

	a_latch_hold: assert property (@(posedge clk_sys_i)
		disable iff (!arst_n_i)
		!port_rd |=> $stable(port_latch_q))
		else $error("port latch moved without a read");

	a_port_free: assert property (@(posedge clk_sys_i)
		disable iff (!arst_n_i)
		wr_en && paddr_i == ADDR_CTRL && !pwdata_i[PORT_FLAG_BIT]
		&& !mismatch |=> !ctrl_q[PORT_FLAG_BIT])
		else $error("port flag not cleared after the mismatch ended");

	a_tmr_poll: assert property (@(posedge clk_sys_i)
		disable iff (!arst_n_i)
		timer_overflow_i && !cfg_q[GLB_EN_BIT] |=> ctrl_q[TMR_FLAG_BIT])
		else $error("timer flag not set while globally disabled");

	a_port_poll: assert property (@(posedge clk_sys_i)
		disable iff (!arst_n_i)
		mismatch && !ctrl_q[PORT_EN_BIT] |=> ctrl_q[PORT_FLAG_BIT])
		else $error("port flag not set while disabled");

	sequence s_fall;
		!cfg_q[POL_BIT] && edge_s3_q ##1 !edge_s3_q;
	endsequence

	a_edge_fall: assert property (@(posedge clk_sys_i)
		disable iff (!arst_n_i)
		s_fall |=> ctrl_q[EDGE_FLAG_BIT])
		else $error("edge flag not set after falling edge");

	a_rise_only: assert property (@(posedge clk_sys_i)
		disable iff (!arst_n_i)
		cfg_q[POL_BIT] && !edge_s2_q |-> !edge_ev)
		else $error("falling edge seen in rising mode");

	a_fall_only: assert property (@(posedge clk_sys_i)
		disable iff (!arst_n_i)
		!cfg_q[POL_BIT] && edge_s2_q |-> !edge_ev)
		else $error("rising edge seen in falling mode");

	// the timer flag alone never reaches the core request
	a_core_none: assert property (@(posedge clk_sys_i)
		disable iff (!arst_n_i)
		!(ctrl_q[EDGE_EN_BIT] && ctrl_q[EDGE_FLAG_BIT])
		&& !(ctrl_q[PORT_EN_BIT] && ctrl_q[PORT_FLAG_BIT])
		|-> !core_irq_o)
		else $error("request raised with no enabled flag");

	a_stat_keep: assert property (@(posedge clk_sys_i)
		disable iff (!arst_n_i)
		!(wr_en && paddr_i == ADDR_STAT)
		|=> (stat_q & $past(stat_q)) == $past(stat_q))
		else $error("status bit dropped without a write");

	a_stat_clear: assert property (@(posedge clk_sys_i)
		disable iff (!arst_n_i)
		wr_en && paddr_i == ADDR_STAT && pwdata_i[TMR_FLAG_BIT]
		&& !timer_overflow_i |=> !stat_q[TMR_FLAG_BIT])
		else $error("status bit not cleared by a one");

	a_mask_hold: assert property (@(posedge clk_sys_i)
		disable iff (!arst_n_i)
		!(wr_en && paddr_i == ADDR_MASK) |=> $stable(mask_q))
		else $error("mask changed without a write");

	a_cfg_hold: assert property (@(posedge clk_sys_i)
		disable iff (!arst_n_i)
		!(wr_en && paddr_i == ADDR_CFG) |=> $stable(cfg_q))
		else $error("config changed without a write");

	a_ready_now: assert property (@(posedge clk_sys_i)
		disable iff (!arst_n_i)
		psel_i && penable_i |-> pready_o && !pslverr_o)
		else $error("access phase not answered at once");

	a_rdata_hold: assert property (@(posedge clk_sys_i)
		disable iff (!arst_n_i)
		!(psel_i && !penable_i) |=> $stable(prdata_o))
		else $error("read data moved outside a setup cycle");
endmodule

// file: verilog/irq_ctrl_pkg.sv
// register map, field positions and reset values for the interrupt block
package irq_ctrl_pkg;
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_PORT = 12'h004;
	localparam logic [11:0] ADDR_CFG = 12'h008;
	localparam logic [11:0] ADDR_STAT = 12'h00c;
	localparam logic [11:0] ADDR_MASK = 12'h010;
	localparam int EDGE_EN_BIT = 4;
	localparam int PORT_EN_BIT = 3;
	localparam int TMR_FLAG_BIT = 2;
	localparam int EDGE_FLAG_BIT = 1;
	localparam int PORT_FLAG_BIT = 0;
	localparam int POL_BIT = 0;
	localparam int GLB_EN_BIT = 1;
	localparam int NUM_EV = 3;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [1:0] CFG_RESET = 2'h1;
	localparam logic [NUM_EV-1:0] EV_RESET = 3'h0;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage
